/* hdl/rcl_defines.svh */
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH

// Register word offsets (byte addresses, one aligned word each).
`define RCL_OFS_ENABLE     8'h00
`define RCL_OFS_MODE       8'h04
`define RCL_OFS_PULLDOWN   8'h08
`define RCL_OFS_QSAVER     8'h0C
`define RCL_OFS_FLTEN      8'h10
`define RCL_OFS_PGOOD      8'h14
`define RCL_OFS_IRQ_STAT   8'h18
`define RCL_OFS_IRQ_CLR    8'h1C
`define RCL_OFS_IRQ_EN     8'h20
`define RCL_OFS_ACTIVE     8'h24
`define RCL_OFS_DELAY0     8'h40
`define RCL_OFS_VCODE0     8'h60
`define RCL_OFS_VCODEB1_0  8'h80

// Reset values.
`define RCL_RST_VCODE      6'h00
`define RCL_RST_DELAY      3'h0

// Timing: one delay unit is 2 ms, the count is derived from the clock rate.
`define RCL_CLK_MHZ        100
`define RCL_DELAY_UNIT_MS  2
`define RCL_DELAY_UNIT_CYC (`RCL_DELAY_UNIT_MS * 1000 * `RCL_CLK_MHZ)

`endif

/* hdl/rcl_pkg.sv */
package rcl_pkg;
	// Per-channel sequencing state.
	typedef enum logic [1:0] {
		RCL_OFF   = 2'b00,
		RCL_WAIT  = 2'b01,
		RCL_RAMP  = 2'b10
	} rcl_state_t;
endpackage

/* hdl/rcl_regulator_control.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`include "rcl_defines.svh"

module rcl_regulator_control
	import rcl_pkg::*;
#(
	parameter int NUM_BUCK  = 3,
	parameter int NUM_CH    = 7,
	parameter int UNIT_CYC  = `RCL_DELAY_UNIT_CYC
) (
	// Clock and reset.
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	// Register port.
	input  wire logic [7:0]           addr_i,
	input  wire logic [31:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [31:0]          rdata_o,
	// Analog side: comparator outputs and bank pin.
	input  wire logic [NUM_CH-1:0]    pgood_raw_i,
	input  wire logic                 voltage_bank_pin_i,
	// Analog side controls.
	output logic [NUM_CH-1:0]         ramp_start_o,
	output logic [NUM_CH*6-1:0]       voltage_code_o,
	output logic [NUM_BUCK-1:0]       forced_pwm_o,
	output logic [NUM_CH-1:0]         pulldown_o,
	output logic [NUM_CH-1:0]         quiescent_saver_o,
	// Interrupts.
	output logic                      interrupt_out_low_o,
	output logic                      irq_o
);

	localparam int CW = 32;

	typedef struct packed {
		logic [NUM_CH-1:0]          en_bit;
		logic [NUM_BUCK-1:0]        mode;
		logic [NUM_CH-1:0]          pulldown_enable;
		logic [NUM_CH-1:0]          qsaver;
		logic [NUM_CH-1:0]          fault_irq_enable;
		logic [NUM_CH-1:0]          latched;
		logic [NUM_CH-1:0]          read_seen;
		logic [NUM_CH-1:0]          stat;
		logic [NUM_CH-1:0]          irq_en;
		logic [NUM_CH-1:0]          active;
		logic [NUM_CH*2-1:0]        st;
		logic [NUM_CH*CW-1:0]       cnt;
		logic [NUM_CH*3-1:0]        delay;
		logic [NUM_CH*6-1:0]        vcode0;
		logic [NUM_BUCK*6-1:0]      vcode1;
		logic [2:0]                 bank_sync;
		logic                       bank;
		logic [NUM_CH*3-1:0]        pg_sync;
		logic [NUM_CH-1:0]          pg;
		logic [31:0]                rdata;
		logic [NUM_CH-1:0]          ramp;
		logic [NUM_CH-1:0]          pdn;
		logic [NUM_CH*6-1:0]        vout;
		logic                       irq_low;
		logic                       irq;
	} rcl_regs_t;

	rcl_regs_t r_ff;
	rcl_regs_t nxt_r;

	// Maps a delay code to its number of 2 ms units; code 0 means none.
	function automatic logic [CW-1:0] units_of(input logic [2:0] code);
		logic [CW-1:0] u;
		u = '0;
		if (code != 3'h0) begin
			u = CW'(1) << (code - 3'h1);
		end
		return u;
	endfunction

	// The next state of every register is formed here in one place.
	always_comb begin
		logic [NUM_CH-1:0] wval;
		logic [NUM_CH-1:0] fault;
		logic [NUM_CH-1:0] evt;
		logic [5:0]        sel;
		logic [2:0]        dcode;
		rcl_state_t        s;
		logic [CW-1:0]     c;
		wval  = wdata_i[NUM_CH-1:0];
		fault = '0;
		evt   = '0;
		sel   = '0;
		dcode = '0;
		s     = RCL_OFF;
		c     = '0;
		nxt_r = r_ff;

		// Pins pass three flops; a change counts once the last two agree.
		nxt_r.bank_sync = {r_ff.bank_sync[1:0], voltage_bank_pin_i};
		if (r_ff.bank_sync[2] == r_ff.bank_sync[1]) begin
			nxt_r.bank = r_ff.bank_sync[2];
		end
		for (int i = 0; i < NUM_CH; i++) begin
			nxt_r.pg_sync[i*3 +: 3] = {r_ff.pg_sync[i*3 +: 2], pgood_raw_i[i]};
			if (r_ff.pg_sync[i*3+2] == r_ff.pg_sync[i*3+1]) begin
				nxt_r.pg[i] = r_ff.pg_sync[i*3+2];
			end
		end

		// Register writes.
		if (wr_i) begin
			case (addr_i)
				`RCL_OFS_ENABLE:   nxt_r.en_bit = wval;
				`RCL_OFS_MODE:     nxt_r.mode = wdata_i[NUM_BUCK-1:0];
				`RCL_OFS_PULLDOWN: nxt_r.pulldown_enable = wval;
				`RCL_OFS_QSAVER:   nxt_r.qsaver = wval;
				`RCL_OFS_FLTEN:    nxt_r.fault_irq_enable = wval;
				`RCL_OFS_IRQ_EN:   nxt_r.irq_en = wval;
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr_i == 8'(`RCL_OFS_DELAY0 + 4 * i)) begin
					nxt_r.delay[i*3 +: 3] = wdata_i[2:0];
				end
				if (addr_i == 8'(`RCL_OFS_VCODE0 + 4 * i)) begin
					nxt_r.vcode0[i*6 +: 6] = wdata_i[5:0];
				end
			end
			for (int i = 0; i < NUM_BUCK; i++) begin
				if (addr_i == 8'(`RCL_OFS_VCODEB1_0 + 4 * i)) begin
					nxt_r.vcode1[i*6 +: 6] = wdata_i[5:0];
				end
			end
		end

		// Only a change of the enable bit acts; a rewrite of the same level does nothing.
		for (int i = 0; i < NUM_CH; i++) begin
			s = rcl_state_t'(r_ff.st[i*2 +: 2]);
			c = r_ff.cnt[i*CW +: CW];
			dcode = r_ff.delay[i*3 +: 3];
			if (nxt_r.en_bit[i] && !r_ff.en_bit[i]) begin
				nxt_r.active[i] = 1'b1;
				s = (dcode == 3'h0) ? RCL_RAMP : RCL_WAIT;
				c = CW'(UNIT_CYC) * units_of(dcode) - CW'(1);
			end else if (!nxt_r.en_bit[i] && r_ff.en_bit[i]) begin
				nxt_r.active[i] = 1'b0;
				s = RCL_OFF;
			end else begin
				case (s)
					RCL_OFF: begin
					end
					RCL_WAIT: begin
						if (c == '0) begin
							s = RCL_RAMP;
						end else begin
							c = c - CW'(1);
						end
					end
					RCL_RAMP: begin
					end
					default: s = RCL_OFF;
				endcase
			end
			nxt_r.st[i*2 +: 2] = s;
			nxt_r.cnt[i*CW +: CW] = c;
			nxt_r.ramp[i] = (s == RCL_RAMP);
		end

		// Converters follow the bank pin; linear regulators use their one code.
		for (int i = 0; i < NUM_CH; i++) begin
			sel = r_ff.vcode0[i*6 +: 6];
			if (i < NUM_BUCK && r_ff.bank) begin
				sel = r_ff.vcode1[i*6 +: 6];
			end
			nxt_r.vout[i*6 +: 6] = sel;
		end

		// The discharge switch is registered from the next state, so the pin comes from a flop.
		// It still opens in the same cycle as the channel turns on, so no overlap with the ramp.
		nxt_r.pdn = nxt_r.pulldown_enable & ~nxt_r.active;

		// Fault holds until the channel is off or in regulation, and status was read.
		for (int i = 0; i < NUM_CH; i++) begin
			fault[i] = r_ff.active[i] && r_ff.ramp[i] && !r_ff.pg[i];
			if (fault[i] && r_ff.fault_irq_enable[i]) begin
				nxt_r.latched[i] = 1'b1;
				nxt_r.read_seen[i] = 1'b0;
			end else if (r_ff.latched[i]) begin
				if (rd_i && addr_i == `RCL_OFS_PGOOD) begin
					nxt_r.read_seen[i] = 1'b1;
				end
				if (!fault[i] && (r_ff.read_seen[i] || (rd_i && addr_i == `RCL_OFS_PGOOD))) begin
					nxt_r.latched[i] = 1'b0;
				end
			end
			evt[i] = fault[i] && !r_ff.latched[i] && r_ff.fault_irq_enable[i];
		end
		nxt_r.irq_low = ~(|nxt_r.latched);

		// Sticky status; a new event beats a clear in the same cycle.
		if (wr_i && addr_i == `RCL_OFS_IRQ_CLR) begin
			nxt_r.stat = r_ff.stat & ~wval;
		end
		nxt_r.stat = nxt_r.stat | evt;
		nxt_r.irq = |(nxt_r.stat & r_ff.irq_en);

		// Read data, valid only in the cycle after the strobe.
		nxt_r.rdata = 32'h0;
		if (rd_i) begin
			case (addr_i)
				`RCL_OFS_ENABLE:   nxt_r.rdata[NUM_CH-1:0] = r_ff.en_bit;
				`RCL_OFS_MODE:     nxt_r.rdata[NUM_BUCK-1:0] = r_ff.mode;
				`RCL_OFS_PULLDOWN: nxt_r.rdata[NUM_CH-1:0] = r_ff.pulldown_enable;
				`RCL_OFS_QSAVER:   nxt_r.rdata[NUM_CH-1:0] = r_ff.qsaver;
				`RCL_OFS_FLTEN:    nxt_r.rdata[NUM_CH-1:0] = r_ff.fault_irq_enable;
				`RCL_OFS_PGOOD:    nxt_r.rdata[NUM_CH-1:0] = r_ff.pg & r_ff.active;
				`RCL_OFS_IRQ_STAT: nxt_r.rdata[NUM_CH-1:0] = r_ff.stat;
				`RCL_OFS_IRQ_EN:   nxt_r.rdata[NUM_CH-1:0] = r_ff.irq_en;
				`RCL_OFS_ACTIVE:   nxt_r.rdata[NUM_CH-1:0] = r_ff.active;
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr_i == 8'(`RCL_OFS_DELAY0 + 4 * i)) begin
					nxt_r.rdata[2:0] = r_ff.delay[i*3 +: 3];
				end
				if (addr_i == 8'(`RCL_OFS_VCODE0 + 4 * i)) begin
					nxt_r.rdata[5:0] = r_ff.vcode0[i*6 +: 6];
				end
			end
			for (int i = 0; i < NUM_BUCK; i++) begin
				if (addr_i == 8'(`RCL_OFS_VCODEB1_0 + 4 * i)) begin
					nxt_r.rdata[5:0] = r_ff.vcode1[i*6 +: 6];
				end
			end
		end
	end

	// All state registers; synchronous reset puts every channel off.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			r_ff <= '0;
			r_ff.irq_low <= 1'b1;
			r_ff.bank_sync <= 3'h0;
			r_ff.delay <= {NUM_CH{`RCL_RST_DELAY}};
			r_ff.vcode0 <= {NUM_CH{`RCL_RST_VCODE}};
			r_ff.vcode1 <= {NUM_BUCK{`RCL_RST_VCODE}};
			r_ff.vout <= {NUM_CH{`RCL_RST_VCODE}};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs straight from flops; the analog side maps codes to volts.
	assign rdata_o             = r_ff.rdata;
	assign ramp_start_o        = r_ff.ramp;
	assign voltage_code_o      = r_ff.vout;
	assign forced_pwm_o        = r_ff.mode;
	assign pulldown_o          = r_ff.pdn;
	assign quiescent_saver_o   = r_ff.qsaver;
	assign interrupt_out_low_o = r_ff.irq_low;
	assign irq_o               = r_ff.irq;

	// Checks next to the logic.
	a_irq_follows_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r_ff.irq_low == ~(|$past(nxt_r.latched))) else $error("Interrupt output disagrees with latches.");
	a_zero_delay_ramp: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_ENABLE && wdata_i[0] && !r_ff.en_bit[0] && r_ff.delay[2:0] == 3'h0)
		|=> ramp_start_o[0]) else $error("Zero delay did not ramp at once.");
	a_level_no_action: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$stable(r_ff.en_bit) |-> $stable(r_ff.active)) else $error("Static enable level changed state.");
	a_fault_latches: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(r_ff.active[0] && r_ff.ramp[0] && !r_ff.pg[0] && r_ff.fault_irq_enable[0]) |=> !interrupt_out_low_o)
		else $error("Enabled fault did not pull interrupt low.");
	a_hold_until_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(r_ff.latched[0] && !r_ff.read_seen[0] && !(rd_i && addr_i == `RCL_OFS_PGOOD)) |=> r_ff.latched[0])
		else $error("Fault latch cleared without status read.");
	a_bank_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r_ff.bank |=> voltage_code_o[5:0] == $past(r_ff.vcode1[5:0])) else $error("Bank pin ignored.");
	a_pulldown_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r_ff.active[3] |-> !pulldown_o[3]) else $error("Pulldown on while enabled.");
	a_read_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!$past(rd_i) |-> rdata_o == 32'h0) else $error("Read data outside its cycle.");
	a_stat_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(r_ff.stat[0] && !(wr_i && addr_i == `RCL_OFS_IRQ_CLR && wdata_i[0])) |=> r_ff.stat[0])
		else $error("Sticky status lost.");

	// Mode and saver bits reach their pins one cycle after the write.
	a_pwm_follows_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_MODE) |=> forced_pwm_o == $past(wdata_i[NUM_BUCK-1:0]))
		else $error("Forced PWM pin does not follow its bit.");
	a_saver_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_QSAVER) |=> quiescent_saver_o == $past(wdata_i[NUM_CH-1:0]))
		else $error("Quiescent saver pin does not follow its bit.");

	// Enable edges: a rising bit starts the channel, a falling bit stops the ramp at once.
	a_rise_activates: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_ENABLE && wdata_i[3] && !r_ff.en_bit[3]) |=> r_ff.active[3])
		else $error("Rising enable did not start the channel.");
	a_fall_stops_ramp: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_ENABLE && !wdata_i[3] && r_ff.en_bit[3]) |=> !ramp_start_o[3])
		else $error("Falling enable left the ramp running.");
	a_no_early_ramp: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `RCL_OFS_ENABLE && wdata_i[3] && !r_ff.en_bit[3] && r_ff.delay[11:9] != 3'h0)
		|=> !ramp_start_o[3]) else $error("Ramp started before its delay.");

	// Pulldown and power-good read paths.
	a_pulldown_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(!r_ff.active[3] && r_ff.pulldown_enable[3]) |-> pulldown_o[3])
		else $error("Pulldown off while disabled.");
	a_pgood_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `RCL_OFS_PGOOD) |=> rdata_o[NUM_CH-1:0] == $past(r_ff.pg & r_ff.active))
		else $error("Power-good read returned the wrong bits.");

	// Fault latch: an unresolved fault keeps the pin low and marks the status.
	a_fault_holds_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(r_ff.latched[0] && r_ff.active[0] && r_ff.ramp[0] && !r_ff.pg[0]) |=> !interrupt_out_low_o)
		else $error("Interrupt released while the fault stands.");
	a_fault_sets_stat: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(r_ff.active[0] && r_ff.ramp[0] && !r_ff.pg[0] && r_ff.fault_irq_enable[0] && !r_ff.latched[0])
		|=> r_ff.stat[0]) else $error("Fault event did not set its status bit.");
	a_irq_needs_stat: assert property (@(posedge core_clk_i) disable iff (rst_i)
		irq_o |-> (|r_ff.stat))
		else $error("Interrupt line high with no status bit.");

	// Voltage codes: converters follow the bank pin, linear channels ignore it.
	a_bank0_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!r_ff.bank |=> voltage_code_o[5:0] == $past(r_ff.vcode0[5:0]))
		else $error("Low bank did not pick the first code.");
	a_linear_own_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
		r_ff.bank |=> voltage_code_o[23:18] == $past(r_ff.vcode0[23:18]))
		else $error("Linear code followed the bank pin.");

endmodule

/* testbench/rcl_analog_model.sv */
// Stands in for the comparators of the seven outputs.
module rcl_analog_model (
	// Clock.
	input  wire logic       core_clk_i,
	// Ramp control from the block and fault injection from the bench.
	input  wire logic [6:0] ramp_start_i,
	input  wire logic [6:0] fault_i,
	// Comparator levels, high while in regulation.
	output logic      [6:0] pgood_raw_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] rise_ff;
	// An output needs time to climb after its ramp starts, so good lags the ramp by two cycles.
	always_ff @(posedge core_clk_i) begin
		rise_ff     <= ramp_start_i;
		pgood_raw_o <= rise_ff & ramp_start_i & ~fault_i;
	end
endmodule

/* testbench/rcl_regulator_control_tb.sv */
module rcl_regulator_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int UNIT = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic        bank;
	logic [6:0]  fault;
	logic [31:0] rdata_o;
	logic [6:0]  pg;
	logic [6:0]  ramp;
	logic [41:0] vc;
	logic [2:0]  fpwm;
	logic [6:0]  pdn;
	logic [6:0]  qsv;
	logic        int_low;
	logic        irq;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n0;
	int          n;

	always #5 clk = ~clk;

	rcl_regulator_control #(.UNIT_CYC(UNIT)) rcl_regulator_control_i (
		.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata_o), .pgood_raw_i(pg), .voltage_bank_pin_i(bank), .ramp_start_o(ramp),
		.voltage_code_o(vc), .forced_pwm_o(fpwm), .pulldown_o(pdn), .quiescent_saver_o(qsv),
		.interrupt_out_low_o(int_low), .irq_o(irq));

	rcl_analog_model rcl_analog_model_i (.core_clk_i(clk), .ramp_start_i(ramp), .fault_i(fault), .pgood_raw_o(pg));

	// Prints the verdict and ends the run.
	task close_out;
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task wr_r(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata_o, e);
	endtask

	// Levels cross three synchroniser flops, so eight cycles covers every path.
	task settle;
		repeat (8) @(posedge clk);
		#1;
	endtask

	// Counts cycles from the enable write to the ramp; differences cancel the fixed latency.
	task on_time(input int ch, input logic [2:0] d, output int cnt);
		wr_r(8'h00, 32'h0);
		settle;
		wr_r(8'(8'h40 + 4 * ch), {29'h0, d});
		wr_r(8'h00, 32'(1 << ch));
		cnt = 0;
		#1;
		while (ramp[ch] !== 1'b1 && cnt < 1000) begin
			@(posedge clk);
			#1 cnt++;
		end
	endtask

	// A hang is cut short here and counted as a mismatch.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end

	initial begin
		addr  = 8'h00;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		bank  = 1'b0;
		fault = 7'h00;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rchk(8'h00, 32'h0);
		rchk(8'h14, 32'h0);
		chk({31'h0, int_low}, 32'h1);
		rchk(8'h3C, 32'h0);
		on_time(3, 3'h0, n0);
		chk({31'h0, n0 <= 3}, 32'h1);
		for (int d = 1; d < 8; d++) begin
			on_time(3, 3'(d), n);
			chk(32'(n - n0), 32'(UNIT << (d - 1)));
		end
		wr_r(8'h00, 32'h08);
		wr_r(8'h08, 32'h08);
		settle;
		chk({31'h0, ramp[3]}, 32'h1);
		chk({31'h0, pdn[3]}, 32'h0);
		wr_r(8'h00, 32'h0);
		settle;
		chk({31'h0, ramp[3]}, 32'h0);
		chk({31'h0, pdn[3]}, 32'h1);
		rchk(8'h24, 32'h0);
		wr_r(8'h04, 32'h5);
		wr_r(8'h0C, 32'h55);
		wr_r(8'h60, 32'h15);
		wr_r(8'h80, 32'h2A);
		wr_r(8'h6C, 32'h3F);
		settle;
		chk({29'h0, fpwm}, 32'h5);
		chk({25'h0, qsv}, 32'h55);
		chk({26'h0, vc[5:0]}, 32'h15);
		chk({26'h0, vc[23:18]}, 32'h3F);
		@(posedge clk) bank <= 1'b1;
		settle;
		chk({26'h0, vc[5:0]}, 32'h2A);
		// Faults are enabled only once the output is up, so the start-up ramp raises none.
		wr_r(8'h40, 32'h0);
		wr_r(8'h00, 32'h1);
		settle;
		wr_r(8'h10, 32'h1);
		wr_r(8'h20, 32'h1);
		rchk(8'h14, 32'h1);
		@(posedge clk) fault <= 7'h01;
		settle;
		chk({31'h0, int_low}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		@(posedge clk) fault <= 7'h00;
		settle;
		chk({31'h0, int_low}, 32'h0);
		rchk(8'h14, 32'h1);
		settle;
		chk({31'h0, int_low}, 32'h1);
		rchk(8'h18, 32'h1);
		wr_r(8'h1C, 32'h1);
		settle;
		chk({31'h0, irq}, 32'h0);
		rchk(8'h18, 32'h0);
		wr_r(8'h10, 32'h0);
		@(posedge clk) fault <= 7'h01;
		settle;
		chk({31'h0, int_low}, 32'h1);
		close_out;
	end
endmodule
